// ===== design/ussr_defines.vh
// Constants for the universal shift and storage register
`ifndef USSR_DEFINES_VH
`define USSR_DEFINES_VH
`define USSR_WIDTH          8
`define USSR_MODE_HOLD      2'h0
`define USSR_MODE_RIGHT     2'h1
`define USSR_MODE_LEFT      2'h2
`define USSR_MODE_LOAD      2'h3
`define USSR_ADDR_W         4
`define USSR_OFF_CTRL       4'h0
`define USSR_OFF_STATUS     4'h4
`define USSR_OFF_SNAP       4'h8
`define USSR_CTRL_STREAM    0
`define USSR_CTRL_RESET     1'h0
`define USSR_ST_DATA_LSB    0
`define USSR_ST_VALID_BIT   8
`define USSR_ST_DROP_LSB    16
`define USSR_BUF_DEPTH      2
`define USSR_BUF_PTR_W      1
`endif

// ===== design/ussr_top.v
// Eight-bit universal shift and storage register with shared ports, stream tap and register slave
// Overview of operation
// R1 - Two select inputs choose hold, shift right, shift left or parallel load.
// R2 - Clear low forces stored bits and serial outputs low immediately.
// R3 - Either drive enable high floats port drivers; register operation continues.
// R4 - Both selects high floats port drivers regardless of enables.
// R5 - In load mode port levels are captured on the rising edge.
// R6 - Both enables low and mode not load: stored word drives ports.
// R7 - Serial outputs always follow first and last stored bits.
// R8 - Right shift moves toward last bit; left shift toward first bit.
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ussr_defines.vh"
module ussr_top #(
   parameter WIDTH = `USSR_WIDTH,
   parameter DEPTH = `USSR_BUF_DEPTH,
   parameter PTR_W = `USSR_BUF_PTR_W
) (
   input  wire                    ref_clk,
   input  wire                    reset,
   input  wire                    async_clear_n,
   input  wire                    func_select_lo,
   input  wire                    func_select_hi,
   input  wire                    port_drive_en_n_a,
   input  wire                    port_drive_en_n_b,
   input  wire                    left_serial_in,
   input  wire                    right_serial_in,
   input  wire [WIDTH-1:0]        port_in,
   output wire [WIDTH-1:0]        port_out,
   output wire [WIDTH-1:0]        port_oe,
   output wire                    first_bit_serial_out,
   output wire                    last_bit_serial_out,
   output wire                    snap_valid,
   input  wire                    snap_ready,
   output wire [WIDTH-1:0]        snap_data,
   output wire                    snap_in_ready,
   input  wire [`USSR_ADDR_W-1:0] avs_address,
   input  wire                    avs_read,
   input  wire                    avs_write,
   input  wire [31:0]             avs_writedata,
   output reg  [31:0]             avs_readdata,
   output wire                    avs_waitrequest
);
   // Two-flop synchronisers for every pin input except the clear
   reg  [WIDTH+5:0] sync_a;
   reg  [WIDTH+5:0] sync_b;
   always @(posedge ref_clk) begin
      if (reset) begin
         sync_a <= {(WIDTH+6){1'b0}};
         sync_b <= {(WIDTH+6){1'b0}};
      end else begin
         sync_a <= {port_in, right_serial_in, left_serial_in, port_drive_en_n_b,
                    port_drive_en_n_a, func_select_hi, func_select_lo};
         sync_b <= sync_a;
      end
   end
   wire [1:0]       mode     = sync_b[1:0];
   wire             en_n_a   = sync_b[2];
   wire             en_n_b   = sync_b[3];
   wire             sl_in    = sync_b[4];
   wire             sr_in    = sync_b[5];
   wire [WIDTH-1:0] par_in   = sync_b[WIDTH+5:6];

   // Bit 0 is the first bit, bit WIDTH-1 the last
   reg  [WIDTH-1:0] stored;
   wire [WIDTH-1:0] next_stored;
   // Each cell picks itself, its lower neighbour, its upper neighbour or its port
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_cell
         wire from_lower;
         wire from_upper;
         if (gi == 0) begin : g_first
            assign from_lower = sr_in; // R8
         end else begin : g_inner_lo
            assign from_lower = stored[gi-1]; // R8
         end
         if (gi == WIDTH-1) begin : g_last
            assign from_upper = sl_in; // R8
         end else begin : g_inner_hi
            assign from_upper = stored[gi+1]; // R8
         end
         reg cell_next;
         always @* begin
            case (mode) // R1
               `USSR_MODE_RIGHT: cell_next = from_lower; // R8
               `USSR_MODE_LEFT:  cell_next = from_upper; // R8
               `USSR_MODE_LOAD:  cell_next = par_in[gi]; // R5
               default:          cell_next = stored[gi];
            endcase
         end
         assign next_stored[gi] = cell_next;
      end
   endgenerate

   // Clear acts without the clock, as a true overriding clear must
   always @(posedge ref_clk or negedge async_clear_n) begin
      if (!async_clear_n) begin
         stored <= {WIDTH{1'b0}}; // R2
      end else if (reset) begin
         stored <= {WIDTH{1'b0}};
      end else begin
         stored <= next_stored; // R3
      end
   end

   assign first_bit_serial_out = stored[0]; // R7
   assign last_bit_serial_out  = stored[WIDTH-1]; // R7
   assign port_out = stored;
   wire drive = ~en_n_a & ~en_n_b & (mode != `USSR_MODE_LOAD); // R3 R4 R6
   // Drivers stay on during reset since the synchronisers then read as hold with enables low
   genvar gd;
   generate
      for (gd = 0; gd < WIDTH; gd = gd + 1) begin : g_drive
         assign port_oe[gd] = drive; // R3 R4 R6
      end
   endgenerate

   // Control register steers the snapshot stream
   reg        stream_en;
   reg        push_pend;
   reg  [7:0] drop_cnt;
   localparam [7:0] DROP_MAX = 8'hFF;

   // Stream tap sees the clear through two flops; the stored word clears at once
   reg        clear_sync_a;
   reg        clear_sync_b;
   always @(posedge ref_clk) begin
      if (reset) begin
         clear_sync_a <= 1'b0;
         clear_sync_b <= 1'b0;
      end else begin
         clear_sync_a <= async_clear_n;
         clear_sync_b <= clear_sync_a;
      end
   end

   // Two-entry snapshot buffer; a full buffer refuses and counts the loss
   reg  [WIDTH-1:0] buf_mem [0:DEPTH-1];
   reg  [PTR_W-1:0] wr_ptr;
   reg  [PTR_W-1:0] rd_ptr;
   reg  [PTR_W:0]   count;
   wire             buf_full  = (count == DEPTH);
   wire             buf_empty = (count == {(PTR_W+1){1'b0}});
   wire             push      = push_pend & stream_en & ~buf_full;
   wire             pop       = snap_ready & ~buf_empty;
   assign snap_valid    = ~buf_empty;
   assign snap_in_ready = ~buf_full;
   assign snap_data     = buf_mem[rd_ptr];

   always @(posedge ref_clk) begin
      if (reset) begin
         wr_ptr    <= {PTR_W{1'b0}};
         rd_ptr    <= {PTR_W{1'b0}};
         count     <= {(PTR_W+1){1'b0}};
         push_pend <= 1'b0;
      end else begin
         // A word is offered one edge after each shift or load seen while the synchronised clear is high
         push_pend <= (mode != `USSR_MODE_HOLD) & clear_sync_b;
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end

   // Storage words carry no reset; only pointers and count need one
   always @(posedge ref_clk) begin
      if (push) begin
         buf_mem[wr_ptr] <= stored;
      end
   end

   // The loss count sticks at its top value rather than wrapping to zero
   always @(posedge ref_clk) begin
      if (reset) begin
         drop_cnt <= 8'h00;
      end else if (push_pend & stream_en & buf_full & (drop_cnt != DROP_MAX)) begin
         drop_cnt <= drop_cnt + 8'h01;
      end
   end

   // Avalon slave: one wait cycle on every access, then the answer
   // Read data is captured in the wait cycle so it stands when waitrequest drops
   reg        ack;
   reg [31:0] next_readdata;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   always @* begin
      case (avs_address)
         `USSR_OFF_CTRL:   next_readdata = {31'h00000000, stream_en};
         `USSR_OFF_STATUS: next_readdata = {8'h00, drop_cnt, 7'h00, ~buf_empty, stored};
         `USSR_OFF_SNAP:   next_readdata = {24'h000000, snap_data};
         default:          next_readdata = 32'h00000000;
      endcase
   end
   always @(posedge ref_clk) begin
      if (reset) begin
         ack          <= 1'b0;
         stream_en    <= `USSR_CTRL_RESET;
         avs_readdata <= 32'h00000000;
      end else begin
         ack <= (avs_read | avs_write) & ~ack;
         // A write lands only at the edge that ends the access, with waitrequest low
         if (avs_write & ack & (avs_address == `USSR_OFF_CTRL)) begin
            stream_en <= avs_writedata[`USSR_CTRL_STREAM];
         end
         if (avs_read & ~ack) begin
            avs_readdata <= next_readdata;
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/ussr_sva.sv
// Port checker for the shift register
`timescale 1ns/100ps
`default_nettype none
module ussr_sva (
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic       async_clear_n,
   input wire logic       func_select_lo,
   input wire logic       func_select_hi,
   input wire logic       port_drive_en_n_a,
   input wire logic       port_drive_en_n_b,
   input wire logic       left_serial_in,
   input wire logic       right_serial_in,
   input wire logic [7:0] port_in,
   input wire logic [7:0] port_out,
   input wire logic [7:0] port_oe,
   input wire logic       first_bit_serial_out,
   input wire logic       last_bit_serial_out
);
   wire  [1:0] m = {func_select_hi, func_select_lo};
   wire        drv = !(port_drive_en_n_a | port_drive_en_n_b) && m != 2'h3;
   logic [2:0] ok;
   // Looks back three edges, so trust them only once reset and clear are gone
   always_ff @(posedge ref_clk) ok <= {ok[1:0], !reset & async_clear_n};
   wire        g = &ok & async_clear_n;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_clear_low: assert property (!async_clear_n |-> {port_out, first_bit_serial_out, last_bit_serial_out} == 10'h000)
      else $error("clear");
   a_serial_ends: assert property ({first_bit_serial_out, last_bit_serial_out} == {port_out[0], port_out[7]})
      else $error("ends");
   a_port_float: assert property (&ok[1:0] && !$past(drv, 2) |-> port_oe == 8'h00) else $error("float");
   a_port_drive: assert property (&ok[1:0] && $past(drv, 2) |-> port_oe == 8'hFF) else $error("drive");
   a_load_take: assert property (g && $past(m, 3) == 2'h3 |-> port_out == $past(port_in, 3)) else $error("load");
   a_shift_right: assert property (g && $past(m, 3) == 2'h1 |->
      port_out == {$past(port_out[6:0]), $past(right_serial_in, 3)}) else $error("right");
   a_shift_left: assert property (g && $past(m, 3) == 2'h2 |->
      port_out == {$past(left_serial_in, 3), $past(port_out[7:1])}) else $error("left");
   a_hold_word: assert property (g && $past(m, 3) == 2'h0 |-> $stable(port_out)) else $error("hold");
endmodule
bind ussr_top ussr_sva u_ussr_sva (
   .ref_clk              (ref_clk),
   .reset                (reset),
   .async_clear_n        (async_clear_n),
   .func_select_lo       (func_select_lo),
   .func_select_hi       (func_select_hi),
   .port_drive_en_n_a    (port_drive_en_n_a),
   .port_drive_en_n_b    (port_drive_en_n_b),
   .left_serial_in       (left_serial_in),
   .right_serial_in      (right_serial_in),
   .port_in              (port_in),
   .port_out             (port_out),
   .port_oe              (port_oe),
   .first_bit_serial_out (first_bit_serial_out),
   .last_bit_serial_out  (last_bit_serial_out)
);
`default_nettype wire

// ===== sim/ussr_bus_model.sv
// Far-side bus model sharing the eight ports
`timescale 1ns/100ps
`default_nettype none
module ussr_bus_model (
   input wire logic       ref_clk,
   input wire logic       drive_en,
   input wire logic [7:0] drive_data,
   input wire logic [7:0] port_out,
   input wire logic [7:0] port_oe,
   output var logic [7:0] port_in
);
   logic [7:0] last = 8'h00;
   // A floating line toggles each cycle so stale data never passes as valid
   always_ff @(posedge ref_clk) last <= port_in;
   always_comb port_in = (port_oe & port_out) | (~port_oe & (drive_en ? drive_data : ~last));
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Testbench for the shift register
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic ref_clk = 0, reset = 1, async_clear_n = 1, func_select_lo = 0, func_select_hi = 0, drive_en = 0;
   logic port_drive_en_n_a = 0, port_drive_en_n_b = 0, left_serial_in = 0, right_serial_in = 0, snap_ready = 0;
   logic avs_read = 0, avs_write = 0, avs_waitrequest, first_bit_serial_out, last_bit_serial_out, snap_valid;
   logic snap_in_ready;
   logic [3:0] avs_address = 4'h0;
   logic [7:0] drive_data = 8'hA5, port_in, port_out, port_oe, snap_data;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   int failures = 0, checks = 0;
   ussr_top u_ussr_top (.*);
   ussr_bus_model u_ussr_bus_model (.*);
   initial forever #2.5 ref_clk = !ref_clk;
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      checks++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
      int waits;
      waits = 0;
      @(posedge ref_clk);
      {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
      // Request holds until an edge sees waitrequest low; data is taken at that edge
      do begin
         @(posedge ref_clk);
         waits++;
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      {avs_write, avs_read} <= 2'h0;
      chk("wait", 32'h2, waits);
   endtask
   // Mode pins pass two flops, so load must stand three edges before the port data is taken
   task automatic run(logic [1:0] m, int n);
      @(posedge ref_clk);
      {func_select_hi, func_select_lo} <= m;
      repeat (n) @(posedge ref_clk);
      {func_select_hi, func_select_lo} <= 2'h0;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #20000 failures++;
      print_verdict;
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      reset <= 0;
      drive_en <= 1;
      run(2'h3, 3);
      chk("load", 8'hA5, port_out);
      chk("ends", 2'h3, {first_bit_serial_out, last_bit_serial_out});
      chk("drive", 8'hFF, port_oe);
      @(posedge ref_clk);
      {right_serial_in, port_drive_en_n_a} <= 2'h3;
      run(2'h1, 3);
      chk("right", 8'h2F, port_out);
      chk("float", 8'h00, port_oe);
      @(posedge ref_clk);
      {port_drive_en_n_a, port_drive_en_n_b} <= 2'h1;
      run(2'h2, 2);
      chk("left", 8'h0B, port_out);
      chk("ends", 2'h2, {first_bit_serial_out, last_bit_serial_out});
      @(posedge ref_clk);
      async_clear_n <= 0;
      @(negedge ref_clk);
      chk("clear", 10'h000, {port_out, first_bit_serial_out, last_bit_serial_out});
      bus(0, 4'h0, 32'h0);
      async_clear_n <= 1;
      chk("ctrl", 32'h0, rd);
      bus(1, 4'h0, 32'h1);
      // Four shifts into a two-entry buffer: two words kept, two dropped
      run(2'h1, 4);
      chk("full", 1'h0, snap_in_ready);
      bus(0, 4'h4, 32'h0);
      chk("status", 32'h0002010F, rd);
      bus(0, 4'h8, 32'h0);
      chk("head", 32'h1, rd);
      bus(0, 4'hC, 32'h0);
      chk("unmapped", 32'h0, rd);
      @(posedge ref_clk);
      snap_ready <= 1;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("next", 8'h03, snap_data);
      @(posedge ref_clk);
      snap_ready <= 0;
      @(negedge ref_clk);
      chk("empty", 1'h0, snap_valid);
      print_verdict;
   end
endmodule
`default_nettype wire
